// ==== drive_profile_pkg.sv ====
`default_nettype none
package drive_profile_pkg;
  // ---------------------------------------------------------------
  // Assembly instances
  // ---------------------------------------------------------------
  localparam logic [7:0] INST_OUT_BASIC = 8'h14;
  localparam logic [7:0] INST_OUT_EXT   = 8'h15;
  localparam logic [7:0] INST_IN_BASIC  = 8'h46;
  localparam logic [7:0] INST_IN_EXT    = 8'h47;
  // Output assembly byte 0 bits
  localparam int OB_RUN_FWD   = 0;
  localparam int OB_RUN_REV   = 1;
  localparam int OB_FAULT_RST = 2;
  // Input assembly byte 0 bits
  localparam int IB_FAULTED = 0;
  localparam int IB_WARNING = 1;
  localparam int IB_RUN_FWD = 2;
  localparam int IB_RUN_REV = 3;
  localparam int IB_READY   = 4;
  localparam int IB_CTRL    = 5;
  localparam int IB_REF     = 6;
  localparam int IB_AT_REF  = 7;
  // Inverter command and status word bits
  localparam int CW_FWD   = 0;
  localparam int CW_REV   = 1;
  localparam int CW_RST   = 15;
  localparam int SW_FWD   = 0;
  localparam int SW_REV   = 1;
  localparam int SW_ACC   = 9;
  localparam int SW_DEC   = 10;
  localparam int SW_ALARM = 11;
  // ---------------------------------------------------------------
  // Scaling: frequency in 0.01 Hz units
  // ---------------------------------------------------------------
  localparam logic [7:0] RPM_PER_HZ    = 8'h78;
  localparam logic [7:0] CENTI_HZ      = 8'h64;
  localparam logic [7:0] DEFAULT_POLES = 8'h04;
  localparam logic [5:0] DIV_STEPS     = 6'h20;
  // Drive states counted as ready
  localparam logic [7:0] DS_READY    = 8'h03;
  localparam logic [7:0] DS_ENABLED  = 8'h04;
  localparam logic [7:0] DS_STOPPING = 8'h05;
  // Object classes and attributes
  localparam logic [7:0] CLS_ASSEMBLY   = 8'h04;
  localparam logic [7:0] CLS_MOTOR      = 8'h28;
  localparam logic [7:0] CLS_SUPERVISOR = 8'h29;
  localparam logic [7:0] CLS_AC_DRIVE   = 8'h2A;
  localparam logic [7:0] ATTR_DATA      = 8'h03;
  localparam logic [7:0] ATTR_POLES     = 8'h0F;
  localparam logic [7:0] ATTR_RUN1      = 8'h03;
  localparam logic [7:0] ATTR_RUN2      = 8'h04;
  localparam logic [7:0] ATTR_STATE     = 8'h06;
  localparam logic [7:0] ATTR_FAULTED   = 8'h0A;
  localparam logic [7:0] ATTR_SPD_ACT   = 8'h07;
  localparam logic [7:0] ATTR_SPD_REF   = 8'h08;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_CMD      = 8'h10;
  localparam logic [7:0] REG_INPUT    = 8'h14;
  localparam logic [7:0] REG_OBJ_SEL  = 8'h18;
  localparam logic [7:0] REG_OBJ_DATA = 8'h1C;
  localparam logic [7:0] CTRL_RESET   = 8'h01;
  localparam int IRQ_W       = 4;
  localparam int IRQ_RX      = 0;
  localparam int IRQ_RST     = 1;
  localparam int IRQ_BAD     = 2;
  localparam int IRQ_FAULTED = 3;
  // Four-byte assembly, byte 0 in the low bits
  typedef struct packed {
    logic [15:0] speed;
    logic [7:0]  aux;
    logic [7:0]  flags;
  } assembly_t;
endpackage
`default_nettype wire

// ==== speed_scaler.sv ====
`timescale 1ns/1ps
`default_nettype none
module speed_scaler (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  // Request
  input  wire logic        i_start,
  input  wire logic [31:0] i_num,
  input  wire logic [15:0] i_den,
  // Result
  output logic             o_busy,
  output logic             o_done,
  output logic [15:0]      o_quot
);
  import drive_profile_pkg::*;

  logic [31:0] quo_q;
  logic [16:0] rem_q;
  logic [15:0] den_q;
  logic [5:0]  cnt_q;
  logic [16:0] shifted;

  // Partial remainder with the next numerator bit
  assign shifted = {rem_q[15:0], quo_q[31]};

  // Restoring divider, one quotient bit per cycle
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      quo_q  <= 32'h0;
      rem_q  <= 17'h0;
      den_q  <= 16'h1;
      cnt_q  <= 6'h0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (o_busy) begin
        if (shifted >= {1'b0, den_q}) begin
          rem_q <= shifted - {1'b0, den_q};
          quo_q <= {quo_q[30:0], 1'b1};
        end else begin
          rem_q <= shifted;
          quo_q <= {quo_q[30:0], 1'b0};
        end
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end
      end else if (i_start) begin
        quo_q  <= i_num;
        rem_q  <= 17'h0;
        den_q  <= i_den;
        cnt_q  <= DIV_STEPS;
        o_busy <= 1'b1;
      end
    end
  end

  // Saturate results that do not fit 16 bits
  assign o_quot = (|quo_q[31:16]) ? 16'hFFFF : quo_q[15:0];
endmodule
`default_nettype wire

// ==== drive_profile_assembly_mapper.sv ====
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Controller uses pair 20/70 or 21/71; both accepted without setup.
// - Assembly, motor, supervisor and drive objects reachable by explicit access.
// - Run-forward bit copied to command word bit 0.
// - Run-reverse bit copied to command word bit 1 for the extended assembly only; basic assembly gives 0.
// - Fault reset bit 15 issued only on a 0-to-1 change.
// - Network-control and network-reference bits are ignored.
// - Speed reference in RPM becomes 0.01 Hz units: times poles and 100, divided by 120.
// - Pole count read once after reset, used for all conversions.
// - Basic input: faulted bit 0, forward bit 2, speed low first.
// - Extended input: eight flags, drive state byte, speed low first.
// - Faulted from status bit 11, forward bit 0, reverse bit 1.
// - Warning, control and reference source flags always zero.
// - Up-to-speed while running and neither accelerating nor decelerating.
// - Actual RPM is output frequency times 120, divided by pole count times 100.
module drive_profile_assembly_mapper (
  // Clock and reset
  input  wire logic                         i_mclk,
  input  wire logic                         i_reset,
  // Wishbone slave
  input  wire logic                         i_wb_cyc,
  input  wire logic                         i_wb_stb,
  input  wire logic                         i_wb_we,
  input  wire logic [7:0]                   i_wb_adr,
  input  wire logic [3:0]                   i_wb_sel,
  input  wire logic [31:0]                  i_wb_dat,
  output logic [31:0]                       o_wb_dat,
  output logic                              o_wb_ack,
  output logic                              o_irq,
  // Cyclic assemblies
  input  wire logic                         i_out_valid,
  input  wire logic [7:0]                   i_out_inst,
  input  wire drive_profile_pkg::assembly_t i_out_asm,
  output drive_profile_pkg::assembly_t      o_in_asm,
  output logic [7:0]                        o_in_inst,
  // Inverter function codes
  output logic                              o_cmd_valid,
  output logic [15:0]                       o_operation_command_word,
  output logic [15:0]                       o_frequency_command,
  input  wire logic [15:0]                  i_operation_status_word,
  input  wire logic [15:0]                  i_output_frequency,
  input  wire logic [7:0]                   i_motor_pole_count,
  input  wire logic [7:0]                   i_drive_state
);
  import drive_profile_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic            wb_req, wb_wr, ack_q;
  logic [7:0]      ctrl_q, poles_q;
  logic            boot_q, ext_q, conn_q, frst_q;
  logic [IRQ_W-1:0] stat_q, mask_q, ev;
  logic [15:0]     obj_sel_q;
  logic            rx_ok, rx_bad, ref_wr, rst_edge;
  logic            p_req_q, p_fwd_q, p_rev_q, p_rst_q;
  logic [15:0]     p_spd_q;
  logic            c_fwd_q, c_rev_q, c_rst_q;
  logic            cmd_start, cmd_busy, cmd_done;
  logic [15:0]     cmd_quot, spd_q;
  logic            st_busy, st_done;
  logic [15:0]     st_quot, spd_act_q;
  logic [31:0]     cmd_num, st_num, obj_data;
  logic [15:0]     st_den;
  logic            run, at_ref, ready, fault_q;
  assembly_t       in_d;

  // ---------------------------------------------------------------
  // Wishbone slave, ack one cycle after the strobe
  // ---------------------------------------------------------------
  assign wb_req = i_wb_cyc & i_wb_stb & ~ack_q;
  assign wb_wr  = wb_req & i_wb_we;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req;
    end
  end
  assign o_wb_ack = ack_q;

  // Read data, unmapped offsets read zero
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_wb_dat <= 32'h0;
    end else if (wb_req) begin
      case (i_wb_adr)
        REG_CTRL:     o_wb_dat <= {24'h0, ctrl_q};
        REG_STATUS:   o_wb_dat <= {16'h0, poles_q, 4'h0, fault_q, conn_q, ext_q, boot_q};
        REG_IRQ_STAT: o_wb_dat <= {28'h0, stat_q};
        REG_IRQ_MASK: o_wb_dat <= {28'h0, mask_q};
        REG_CMD:      o_wb_dat <= {o_frequency_command, o_operation_command_word};
        REG_INPUT:    o_wb_dat <= o_in_asm;
        REG_OBJ_SEL:  o_wb_dat <= {16'h0, obj_sel_q};
        REG_OBJ_DATA: o_wb_dat <= obj_data;
        default:      o_wb_dat <= 32'h0;
      endcase
    end
  end

  // Control, mask and object select registers
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ctrl_q    <= CTRL_RESET;
      mask_q    <= '0;
      obj_sel_q <= 16'h0;
    end else if (wb_wr) begin
      if (i_wb_adr == REG_CTRL && i_wb_sel[0]) begin
        ctrl_q <= i_wb_dat[7:0];
      end
      if (i_wb_adr == REG_IRQ_MASK && i_wb_sel[0]) begin
        mask_q <= i_wb_dat[IRQ_W-1:0];
      end
      if (i_wb_adr == REG_OBJ_SEL && i_wb_sel[0]) begin
        obj_sel_q[7:0] <= i_wb_dat[7:0];
      end
      if (i_wb_adr == REG_OBJ_SEL && i_wb_sel[1]) begin
        obj_sel_q[15:8] <= i_wb_dat[15:8];
      end
    end
  end

  // ---------------------------------------------------------------
  // Explicit attribute access: class in [15:8], attribute in [7:0]
  // ---------------------------------------------------------------
  always_comb begin
    obj_data = 32'h0;
    case (obj_sel_q[15:8])
      CLS_ASSEMBLY: if (obj_sel_q[7:0] == ATTR_DATA) obj_data = o_in_asm;
      CLS_MOTOR: if (obj_sel_q[7:0] == ATTR_POLES) obj_data = {24'h0, poles_q};
      CLS_SUPERVISOR: begin
        case (obj_sel_q[7:0])
          ATTR_RUN1:    obj_data = {31'h0, c_fwd_q};
          ATTR_RUN2:    obj_data = {31'h0, c_rev_q};
          ATTR_STATE:   obj_data = {24'h0, i_drive_state};
          ATTR_FAULTED: obj_data = {31'h0, fault_q};
          default:      obj_data = 32'h0;
        endcase
      end
      CLS_AC_DRIVE: begin
        case (obj_sel_q[7:0])
          ATTR_SPD_ACT: obj_data = {16'h0, spd_act_q};
          ATTR_SPD_REF: obj_data = {16'h0, p_spd_q};
          default:      obj_data = 32'h0;
        endcase
      end
      default: obj_data = 32'h0;
    endcase
  end

  // Write of the drive speed reference attribute
  assign ref_wr = wb_wr && i_wb_adr == REG_OBJ_DATA && (&i_wb_sel[1:0])
                  && obj_sel_q == {CLS_AC_DRIVE, ATTR_SPD_REF};

  // ---------------------------------------------------------------
  // Pole count caught once after reset release
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      boot_q  <= 1'b0;
      poles_q <= DEFAULT_POLES;
    end else if (!boot_q) begin
      boot_q <= 1'b1;
      if (i_motor_pole_count != 8'h00) begin
        poles_q <= i_motor_pole_count;
      end
    end
  end

  // ---------------------------------------------------------------
  // Output assembly receipt
  // ---------------------------------------------------------------
  assign rx_ok  = i_out_valid && (i_out_inst == INST_OUT_BASIC
                  || i_out_inst == INST_OUT_EXT);
  assign rx_bad = i_out_valid && !rx_ok;
  assign rst_edge = rx_ok && i_out_asm.flags[OB_FAULT_RST] && !frst_q;

  // Active pair and last fault reset level
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ext_q  <= 1'b0;
      conn_q <= 1'b0;
      frst_q <= 1'b0;
    end else if (rx_ok) begin
      ext_q  <= i_out_inst == INST_OUT_EXT;
      conn_q <= 1'b1;
      frst_q <= i_out_asm.flags[OB_FAULT_RST];
    end
  end

  // Pending command; bits 5 and 6 are never looked at
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      p_req_q <= 1'b0;
      p_fwd_q <= 1'b0;
      p_rev_q <= 1'b0;
      p_rst_q <= 1'b0;
      p_spd_q <= 16'h0;
    end else begin
      if (rx_ok) begin
        p_fwd_q <= i_out_asm.flags[OB_RUN_FWD];
        p_rev_q <= (i_out_inst == INST_OUT_EXT) && i_out_asm.flags[OB_RUN_REV];
        p_spd_q <= i_out_asm.speed;
      end else if (ref_wr) begin
        p_spd_q <= i_wb_dat[15:0];
      end
      if (rx_ok || ref_wr) begin
        p_req_q <= 1'b1;
      end else if (cmd_start) begin
        p_req_q <= 1'b0;
      end
      if (rst_edge) begin
        p_rst_q <= 1'b1;
      end else if (cmd_start) begin
        p_rst_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Speed reference to frequency command
  // ---------------------------------------------------------------
  assign cmd_start = p_req_q && !cmd_busy && boot_q;
  assign cmd_num = 32'(p_spd_q * poles_q) * 32'(CENTI_HZ);

  speed_scaler u_cmd_scaler (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_start (cmd_start),
    .i_num   (cmd_num),
    .i_den   ({8'h00, RPM_PER_HZ}),
    .o_busy  (cmd_busy),
    .o_done  (cmd_done),
    .o_quot  (cmd_quot)
  );

  // Command fields frozen while the division runs
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      c_fwd_q <= 1'b0;
      c_rev_q <= 1'b0;
      c_rst_q <= 1'b0;
      spd_q   <= 16'h0;
    end else if (cmd_start) begin
      c_fwd_q <= p_fwd_q;
      c_rev_q <= p_rev_q;
      c_rst_q <= p_rst_q;
      spd_q   <= p_spd_q;
    end
  end

  // Inverter command write; reset bit stands for one write only
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_cmd_valid              <= 1'b0;
      o_operation_command_word <= 16'h0;
      o_frequency_command      <= 16'h0;
    end else begin
      o_cmd_valid <= cmd_done && ctrl_q[0];
      o_operation_command_word[CW_RST] <= 1'b0;
      if (cmd_done && ctrl_q[0]) begin
        o_operation_command_word[CW_FWD] <= c_fwd_q;
        o_operation_command_word[CW_REV] <= c_rev_q;
        o_operation_command_word[CW_RST] <= c_rst_q;
        o_frequency_command              <= cmd_quot;
      end
    end
  end

  // ---------------------------------------------------------------
  // Output frequency to actual speed, free running
  // ---------------------------------------------------------------
  assign st_num = 32'(i_output_frequency * RPM_PER_HZ);
  assign st_den = 16'(poles_q * CENTI_HZ);

  speed_scaler u_stat_scaler (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_start (boot_q),
    .i_num   (st_num),
    .i_den   (st_den),
    .o_busy  (st_busy),
    .o_done  (st_done),
    .o_quot  (st_quot)
  );

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      spd_act_q <= 16'h0;
    end else if (st_done) begin
      spd_act_q <= st_quot;
    end
  end

  // ---------------------------------------------------------------
  // Input assembly packing
  // ---------------------------------------------------------------
  assign run = i_operation_status_word[SW_FWD] | i_operation_status_word[SW_REV];
  assign at_ref = run && !i_operation_status_word[SW_ACC]
                  && !i_operation_status_word[SW_DEC];
  assign ready = i_drive_state == DS_READY || i_drive_state == DS_ENABLED
                 || i_drive_state == DS_STOPPING;

  always_comb begin
    in_d = '0;
    in_d.speed = spd_act_q;
    in_d.flags[IB_FAULTED] = i_operation_status_word[SW_ALARM];
    in_d.flags[IB_RUN_FWD] = i_operation_status_word[SW_FWD];
    if (ext_q) begin
      in_d.flags[IB_RUN_REV] = i_operation_status_word[SW_REV];
      in_d.flags[IB_READY]   = ready;
      in_d.flags[IB_AT_REF]  = at_ref;
      in_d.aux               = i_drive_state;
    end
    in_d.flags[IB_WARNING] = 1'b0;
    in_d.flags[IB_CTRL]    = 1'b0;
    in_d.flags[IB_REF]     = 1'b0;
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_in_asm  <= '0;
      o_in_inst <= INST_IN_BASIC;
      fault_q   <= 1'b0;
    end else begin
      o_in_asm  <= in_d;
      o_in_inst <= ext_q ? INST_IN_EXT : INST_IN_BASIC;
      fault_q   <= i_operation_status_word[SW_ALARM];
    end
  end

  // ---------------------------------------------------------------
  // Interrupts: sticky status, write one to clear, set wins
  // ---------------------------------------------------------------
  assign ev[IRQ_RX]      = rx_ok;
  assign ev[IRQ_RST]     = o_cmd_valid && o_operation_command_word[CW_RST];
  assign ev[IRQ_BAD]     = rx_bad;
  assign ev[IRQ_FAULTED] = i_operation_status_word[SW_ALARM] && !fault_q;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      stat_q <= '0;
      o_irq  <= 1'b0;
    end else begin
      if (wb_wr && i_wb_adr == REG_IRQ_STAT && i_wb_sel[0]) begin
        stat_q <= (stat_q & ~i_wb_dat[IRQ_W-1:0]) | ev;
      end else begin
        stat_q <= stat_q | ev;
      end
      o_irq <= |(stat_q & mask_q);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_bus_ack: assert property (@(posedge i_mclk) disable iff (i_reset)
    wb_req |=> o_wb_ack ##1 !o_wb_ack) else $error("bus ack timing wrong");
  a_pair_accept: assert property (@(posedge i_mclk) disable iff (i_reset)
    rx_ok |=> conn_q && (ext_q == $past(i_out_inst == INST_OUT_EXT)))
    else $error("assembly pair not taken");
  a_cmd_copy: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_cmd_valid |-> o_operation_command_word[CW_FWD] == $past(c_fwd_q)
      && o_operation_command_word[CW_REV] == $past(c_rev_q)
      && o_operation_command_word[14:2] == 13'h0) else $error("command bits wrong");
  a_basic_rev: assert property (@(posedge i_mclk) disable iff (i_reset)
    (rx_ok && i_out_inst == INST_OUT_BASIC) |=> !p_rev_q)
    else $error("reverse set by basic assembly");
  a_rst_edge: assert property (@(posedge i_mclk) disable iff (i_reset)
    (rx_ok && (frst_q || !i_out_asm.flags[OB_FAULT_RST]) && !p_rst_q) |=> !p_rst_q)
    else $error("reset issued without edge");
  a_rst_pulse: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_operation_command_word[CW_RST] |-> o_cmd_valid ##1 !o_operation_command_word[CW_RST])
    else $error("reset bit held");
  a_freq_scale: assert property (@(posedge i_mclk) disable iff (i_reset)
    cmd_done |-> cmd_quot == ((((32'(spd_q * poles_q) * 32'(CENTI_HZ)) / 32'(RPM_PER_HZ))
      > 32'h0000FFFF) ? 16'hFFFF
      : 16'((32'(spd_q * poles_q) * 32'(CENTI_HZ)) / 32'(RPM_PER_HZ))))
    else $error("frequency scale wrong");
  a_poles_fixed: assert property (@(posedge i_mclk) disable iff (i_reset)
    boot_q |=> $stable(poles_q)) else $error("pole count changed");
  a_basic_pack: assert property (@(posedge i_mclk) disable iff (i_reset)
    (!i_reset && !ext_q) |=> o_in_asm.aux == 8'h00 && o_in_asm.flags[7:3] == 5'h0)
    else $error("basic input packing wrong");
  a_fault_map: assert property (@(posedge i_mclk) disable iff (i_reset)
    !i_reset |=> o_in_asm.flags[IB_FAULTED] == $past(i_operation_status_word[SW_ALARM]))
    else $error("faulted flag wrong");
  a_flag_zero: assert property (@(posedge i_mclk) disable iff (i_reset)
    !o_in_asm.flags[IB_WARNING] && !o_in_asm.flags[IB_CTRL] && !o_in_asm.flags[IB_REF])
    else $error("unused flag set");
  a_at_ref: assert property (@(posedge i_mclk) disable iff (i_reset)
    (!i_reset && ext_q) |=> o_in_asm.flags[IB_AT_REF] == $past(at_ref))
    else $error("up-to-speed flag wrong");
  a_irq_level: assert property (@(posedge i_mclk) disable iff (i_reset)
    !i_reset |=> o_irq == $past(|(stat_q & mask_q))) else $error("irq level wrong");
endmodule
`default_nettype wire

// ==== scanner_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Network controller model
// ------------------------------------------------------------
module scanner_model (
  // Clock and request from the bench
  input  wire logic                    i_mclk,
  input  wire logic                    i_go,
  input  wire logic [7:0]              i_inst,
  input  wire logic [7:0]              i_flags,
  input  wire logic [15:0]             i_rpm,
  // Output assembly toward the mapper
  output logic                         o_out_valid,
  output logic [7:0]                   o_out_inst,
  output drive_profile_pkg::assembly_t o_out_asm
);
  import drive_profile_pkg::*;
  logic [7:0] cnt_q = 8'h00;
  // One-cycle frame; outside it speed and flags show inverted junk, aux is a free counter
  always_ff @(posedge i_mclk) begin
    cnt_q       <= cnt_q + 8'h01;
    o_out_valid <= i_go;
    o_out_inst  <= i_inst;
    o_out_asm   <= '{speed: i_go ? i_rpm : ~i_rpm, aux: cnt_q,
                     flags: i_go ? i_flags : ~i_flags};
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import drive_profile_pkg::*;
  logic        i_mclk, i_reset, cyc, we, go, ack, irq, cmd_valid, out_valid, prev_rst, ext_sel;
  logic [7:0]  adr, inst, flags, in_inst, out_inst, poles, dstate;
  logic [31:0] wdat, rdat, rd;
  logic [15:0] rpm, cmdw, freq, sw, ofreq;
  assembly_t   out_asm, in_asm;
  int          n_mismatch, comparisons, seed, i;
  // ------------------------------------------------------------
  // Clock, partner and design
  // ------------------------------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  scanner_model u_scanner_model (.i_mclk(i_mclk), .i_go(go), .i_inst(inst), .i_flags(flags),
    .i_rpm(rpm), .o_out_valid(out_valid), .o_out_inst(out_inst), .o_out_asm(out_asm));
  drive_profile_assembly_mapper u_drive_profile_assembly_mapper (.i_mclk(i_mclk),
    .i_reset(i_reset), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_irq(irq),
    .i_out_valid(out_valid), .i_out_inst(out_inst), .i_out_asm(out_asm), .o_in_asm(in_asm),
    .o_in_inst(in_inst), .o_cmd_valid(cmd_valid), .o_operation_command_word(cmdw),
    .o_frequency_command(freq), .i_operation_status_word(sw), .i_output_frequency(ofreq),
    .i_motor_pole_count(poles), .i_drive_state(dstate));
  // ------------------------------------------------------------
  // Checks, expectations and bus tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Pole count latched at boot is 6; later input changes must not matter
  function automatic logic [15:0] exp_freq(input logic [15:0] r);
    logic [31:0] t;
    t = 32'(r) * 32'd6 * 32'(CENTI_HZ) / 32'(RPM_PER_HZ);
    return (t > 32'h0000FFFF) ? 16'hFFFF : t[15:0];
  endfunction
  function automatic logic [7:0] exp_flags(input logic [15:0] s, input logic [7:0] d);
    logic run;
    run = s[SW_FWD] | s[SW_REV];
    return {run & ~s[SW_ACC] & ~s[SW_DEC], 2'b00, d inside {DS_READY, DS_ENABLED, DS_STOPPING},
            s[SW_REV], s[SW_FWD], 1'b0, s[SW_ALARM]};
  endfunction
  // Classic single Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    cyc <= 1'b1; we <= w; adr <= a; wdat <= d;
    k = 0;
    do begin @(posedge i_mclk); k++; end while (ack !== 1'b1 && k < 20);
    rd = rdat;
    cyc <= 1'b0;
    if (k >= 20) begin n_mismatch++; finish_test(); end
    @(posedge i_mclk);
  endtask
  // Send one output assembly and check the resulting inverter write
  task automatic send(input logic [7:0] ins, input logic [7:0] f, input logic [15:0] r);
    int k;
    logic ext;
    ext = (ins == INST_OUT_EXT);
    go <= 1'b1; inst <= ins; flags <= f; rpm <= r;
    @(posedge i_mclk);
    go <= 1'b0;
    if (ext || ins == INST_OUT_BASIC) begin
      k = 0;
      do begin @(posedge i_mclk); k++; end while (cmd_valid !== 1'b1 && k < 200);
      if (k >= 200) begin n_mismatch++; finish_test(); end
      check("cmd_word", 32'(cmdw), 32'({f[OB_FAULT_RST] & ~prev_rst, 13'h0000,
            f[OB_RUN_REV] & ext, f[OB_RUN_FWD]}));
      check("freq_cmd", 32'(freq), 32'(exp_freq(r)));
      prev_rst = f[OB_FAULT_RST];
      @(posedge i_mclk);
      check("in_inst", 32'(in_inst), 32'(ext ? INST_IN_EXT : INST_IN_BASIC));
    end
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'h12bd73bb; prev_rst = 1'b0; n_mismatch = 0; comparisons = 0;
    i_reset <= 1'b1; cyc <= 1'b0; we <= 1'b0; adr <= 8'h00; wdat <= 32'h0; go <= 1'b0;
    inst <= 8'h00; flags <= 8'h00; rpm <= 16'h0000; sw <= 16'h0000; ofreq <= 16'h0000;
    dstate <= 8'h00; poles <= 8'h06;
    repeat (8) @(posedge i_mclk);
    i_reset <= 1'b0;
    @(posedge i_mclk);
    poles <= 8'h02;
    check("in_inst_rst", 32'(in_inst), 32'(INST_IN_BASIC));
    wb(1'b1, REG_IRQ_MASK, 32'h1);
    send(INST_OUT_EXT, 8'h65, 16'hFFFF);
    send(INST_OUT_EXT, 8'h04, 16'h0000);
    send(INST_OUT_BASIC, 8'h06, 16'h0708);
    check("irq_set", 32'(irq), 32'h1);
    wb(1'b1, REG_IRQ_STAT, 32'h1);
    check("irq_clr", 32'(irq), 32'h0);
    wb(1'b1, REG_IRQ_MASK, 32'h0);
    send(8'h33, 8'h01, 16'h0100);
    repeat (4) @(posedge i_mclk);
    wb(1'b0, REG_IRQ_STAT, 32'h0);
    check("irq_bad", 32'({irq, rd[IRQ_BAD]}), 32'h1);
    wb(1'b0, 8'hF0, 32'h0);
    check("unmapped", rd, 32'h0);
    for (i = 0; i < 12; i++) begin
      ext_sel = 1'($random(seed) & 1);
      send(ext_sel ? INST_OUT_EXT : INST_OUT_BASIC, 8'($random(seed)),
           16'($random(seed)));
      sw <= 16'($random(seed)); dstate <= 8'($random(seed) & 7); ofreq <= 16'($random(seed));
      repeat (80) @(posedge i_mclk);
      check("speed_act", 32'(in_asm.speed), 32'(32'(ofreq) * 120 / 600));
      if (ext_sel) check("flags_ext", 32'({in_asm.aux, in_asm.flags}),
          32'({dstate, exp_flags(sw, dstate)}));
      else check("flags_basic", 32'({in_asm.aux, in_asm.flags}),
          32'({8'h00, exp_flags(sw, dstate) & 8'h05}));
    end
    wb(1'b1, REG_OBJ_SEL, 32'({CLS_MOTOR, ATTR_POLES}));
    wb(1'b0, REG_OBJ_DATA, 32'h0);
    check("obj_poles", rd, 32'h6);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    @(posedge i_mclk);
    wb(1'b0, REG_STATUS, 32'h0);
    check("poles_reboot", 32'(rd[15:8]), 32'h2);
    finish_test();
  end
endmodule
`default_nettype wire
